// file: inc/pmra_pkg.sv
// Shared constants and types for the power monitor readback and alert block
package pmra_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Write targets: command byte or one of the extended registers
    localparam logic [1:0] PMRA_WR_COMMAND  = 2'h0;
    localparam logic [1:0] PMRA_EXT_ALERTEN = 2'h1;
    localparam logic [1:0] PMRA_EXT_ALERTTH = 2'h2;
    localparam logic [1:0] PMRA_EXT_CONTROL = 2'h3;
    localparam int unsigned PMRA_EXT_FLAG_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Command byte fields
    localparam int unsigned PMRA_CMD_V_CONT = 0;
    localparam int unsigned PMRA_CMD_V_ONCE = 1;
    localparam int unsigned PMRA_CMD_I_CONT = 2;
    localparam int unsigned PMRA_CMD_I_ONCE = 3;
    localparam int unsigned PMRA_CMD_VRANGE = 4;
    localparam int unsigned PMRA_CMD_STATUS = 6;
    localparam logic [6:0]  PMRA_CMD_RESET  = 7'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Alert enable fields
    localparam int unsigned PMRA_AEN_ADC1  = 0;
    localparam int unsigned PMRA_AEN_ADC4  = 1;
    localparam int unsigned PMRA_AEN_OC    = 2;
    localparam int unsigned PMRA_AEN_OFF   = 3;
    localparam int unsigned PMRA_AEN_CLEAR = 4;
    localparam logic [3:0]  PMRA_AEN_RESET = 4'h4;

    ////////////////////////////////////////////////////////////////////////////
    // Threshold, force-off control and status layout
    localparam logic [7:0]  PMRA_TH_RESET     = 8'hff;
    localparam int unsigned PMRA_CTRL_SOFTOFF = 0;
    localparam logic        PMRA_CTRL_RESET   = 1'b0;
    localparam int unsigned PMRA_ST_ADC_OVERCURRENT_SEEN    = 0;
    localparam int unsigned PMRA_ST_ADC_ALERT = 1;
    localparam int unsigned PMRA_ST_OC_LIVE   = 2;
    localparam int unsigned PMRA_ST_OC_LATCH  = 3;
    localparam int unsigned PMRA_ST_OFF_STAT  = 4;
    localparam int unsigned PMRA_ST_OFF_ALERT = 5;
    localparam int unsigned PMRA_ST_W         = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Link sequencing
    localparam logic [2:0] PMRA_BIT_LAST   = 3'h7;
    localparam logic [2:0] PMRA_BITS_AT_SEEN = 3'h2;
    localparam int unsigned PMRA_CODE_W    = 12;

    typedef enum logic [6:0] {
        PMRA_IDLE     = 7'h01,
        PMRA_ADDR     = 7'h02,
        PMRA_ADDR_ACK = 7'h04,
        PMRA_WR_BYTE  = 7'h08,
        PMRA_WR_ACK   = 7'h10,
        PMRA_RD_BYTE  = 7'h20,
        PMRA_RD_ACK   = 7'h40
    } pmra_link_state_t;

endpackage

// file: logic/pmra_sync.sv
// Two flip-flop level synchroniser, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none
module pmra_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Destination clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Levels from another domain and their synchronised copy
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    ////////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// file: logic/pmra_top.sv
// Power monitor readback, alert status and serial slave link
//
// Functional notes
// - Soft-off releases alert only with its enable
// - Dual read: V msb, I msb, nibbles
// - Voltage-only: V msb, V lsb nibble, zeros
// - Current-only: I msb, I lsb nibble, zeros
// - Read: address ack, bytes, master nacks last
// - Status read returns exactly one status byte
// - Bit0: last three conversions over threshold
// - Bit1: conversion trip latched until clear
// - Bit2: live comparator state, no latch
// - Bit3: comparator trip latched, alert asserts
// - Bit4: set by writing soft-off bit
// - Bit5: soft-off alert latched until clear
// - Alert pin open drain, low on fault
// - Comparator above trip level sources alert
// - Status-read command selects status byte
// - Clear self-clears; active sources set again
// - Nack reads while single shot pending
`timescale 1ns/10ps
`default_nettype none
module pmra_top
    import pmra_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h30
) (
    // Core clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // Serial link, clock from the master
    input  wire logic                   scl_clk,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    // Alert pin, open drain
    output logic                        alert_output_n_out,
    output logic                        alert_output_n_oe,
    // Analog comparator: sense amp above trip_threshold_input
    input  wire logic                   trip_compare_in,
    // Conversion results, core domain
    input  wire logic                   adc_v_done,
    input  wire logic [PMRA_CODE_W-1:0] adc_v_code,
    input  wire logic                   adc_i_done,
    input  wire logic [PMRA_CODE_W-1:0] adc_i_code,
    // Conversion control towards the converter
    output logic                        conv_v_cont,
    output logic                        conv_v_once,
    output logic                        conv_i_cont,
    output logic                        conv_i_once,
    output logic                        vrange_sel
);

    ////////////////////////////////////////////////////////////////////////////
    // Read byte packing
    function automatic logic [7:0] pmra_read_byte(
        input logic [1:0]             idx,
        input logic                   sel_v,
        input logic                   sel_i,
        input logic                   sel_st,
        input logic [PMRA_CODE_W-1:0] v,
        input logic [PMRA_CODE_W-1:0] i,
        input logic [7:0]             st
    );
        logic [7:0] b;
        b = 8'h00;
        if (sel_st) begin
            if (idx == 2'h0) b = st;
        end else if (sel_v && !sel_i) begin
            case (idx)
                2'h0:    b = v[11:4];
                2'h1:    b = {v[3:0], 4'h0};
                default: b = 8'h00;
            endcase
        end else if (sel_i && !sel_v) begin
            case (idx)
                2'h0:    b = i[11:4];
                2'h1:    b = {i[3:0], 4'h0};
                default: b = 8'h00;
            endcase
        end else begin
            case (idx)
                2'h0:    b = v[11:4];
                2'h1:    b = i[11:4];
                2'h2:    b = {v[3:0], i[3:0]};
                default: b = 8'h00;
            endcase
        end
        return b;
    endfunction

    // Core side state
    logic [6:0]             cmd_reg;
    logic [3:0]             alert_en_reg;
    logic [7:0]             alert_threshold_reg;
    logic                   soft_off_bit;
    logic [2:0]             over_hist_reg;
    logic                   adc_alert_reg;
    logic                   overcurrent_latched;
    logic                   off_status_reg;
    logic                   off_alert_reg;
    logic                   alert_oe_reg;
    logic [PMRA_CODE_W-1:0] v_hold_reg;
    logic [PMRA_CODE_W-1:0] i_hold_reg;
    logic                   data_tog_reg;
    logic                   start_tog_reg;
    logic                   sda_prev_reg;
    logic                   wr_prev_reg;
    logic [3:0]             core_sync_q;
    logic                   scl_s;
    logic                   sda_s;
    logic                   overcurrent_live;
    logic                   wr_tog_s;
    logic                   wr_evt;
    logic                   clear_evt;
    logic [3:0]             alert_en_eff;
    logic                   i_over;
    logic                   adc_overcurrent_seen;
    logic [7:0]             status_byte;

    // Link side state
    pmra_link_state_t       state_reg;
    logic [2:0]             cnt_reg;
    logic [7:0]             shift_reg;
    logic [7:0]             byte_in;
    logic                   start_meta_reg;
    logic                   start_s_reg;
    logic                   start_seen_reg;
    logic                   start_new;
    logic                   rw_reg;
    logic [1:0]             idx_reg;
    logic [7:0]             tx_reg;
    logic                   ptr_pend_reg;
    logic [1:0]             ptr_reg;
    logic                   wr_tog_reg;
    logic [1:0]             wr_kind_reg;
    logic [7:0]             wr_data_reg;
    logic                   sel_v_reg;
    logic                   sel_i_reg;
    logic                   sel_st_reg;
    logic [PMRA_CODE_W-1:0] v_snap_reg;
    logic [PMRA_CODE_W-1:0] i_snap_reg;
    logic                   data_seen_reg;
    logic [PMRA_ST_W+1:0]   link_sync_q;
    logic                   pend_s;
    logic                   data_tog_s;
    logic                   sda_oe_reg;
    logic [1:0]             idx_next;

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: synchronise pins and the link write toggle
    pmra_sync #(.WIDTH(4)) u_core_sync (
        .clk (core_clk),
        .rst (rst),
        .d   ({wr_tog_reg, trip_compare_in, sda_in, scl_clk}),
        .q   (core_sync_q)
    );
    assign scl_s            = core_sync_q[0];
    assign sda_s            = core_sync_q[1];
    assign overcurrent_live = core_sync_q[2];
    assign wr_tog_s         = core_sync_q[3];

    // Start is sda falling while scl high; the link clock alone cannot see it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sda_prev_reg  <= 1'b1;
            start_tog_reg <= 1'b0;
        end else begin
            sda_prev_reg <= sda_s;
            if (scl_s && sda_prev_reg && !sda_s)
                start_tog_reg <= ~start_tog_reg;
        end
    end

    // Write events arrive as a toggle; kind and data stay still for a byte
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_prev_reg <= 1'b0;
        end else begin
            wr_prev_reg <= wr_tog_s;
        end
    end
    assign wr_evt    = wr_tog_s ^ wr_prev_reg;
    assign clear_evt = wr_evt && (wr_kind_reg == PMRA_EXT_ALERTEN)
                       && wr_data_reg[PMRA_AEN_CLEAR];
    // A source disabled by the same write that clears must not re-set its flag
    assign alert_en_eff = (wr_evt && (wr_kind_reg == PMRA_EXT_ALERTEN)) ? wr_data_reg[3:0]
                          : alert_en_reg;

    // Command byte; single-shot bits drop when their conversion lands
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmd_reg <= PMRA_CMD_RESET;
        end else if (wr_evt && (wr_kind_reg == PMRA_WR_COMMAND)) begin
            cmd_reg <= wr_data_reg[6:0];
        end else begin
            if (adc_v_done) cmd_reg[PMRA_CMD_V_ONCE] <= 1'b0;
            if (adc_i_done) cmd_reg[PMRA_CMD_I_ONCE] <= 1'b0;
        end
    end

    // Extended registers; clear bit is a strobe and is never stored
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            alert_en_reg        <= PMRA_AEN_RESET;
            alert_threshold_reg <= PMRA_TH_RESET;
            soft_off_bit        <= PMRA_CTRL_RESET;
        end else if (wr_evt) begin
            case (wr_kind_reg)
                PMRA_EXT_ALERTEN: alert_en_reg        <= wr_data_reg[3:0];
                PMRA_EXT_ALERTTH: alert_threshold_reg <= wr_data_reg;
                PMRA_EXT_CONTROL: soft_off_bit <= wr_data_reg[PMRA_CTRL_SOFTOFF];
                default:          ;
            endcase
        end
    end

    // Conversion history, newest in bit 0
    assign i_over = adc_i_code[11:4] > alert_threshold_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            over_hist_reg <= 3'h0;
        end else if (adc_i_done) begin
            over_hist_reg <= {over_hist_reg[1:0], i_over};
        end
    end
    assign adc_overcurrent_seen = &over_hist_reg[2:0];

    // Latched flags; a set in the clear cycle wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            adc_alert_reg       <= 1'b0;
            overcurrent_latched <= 1'b0;
            off_alert_reg       <= 1'b0;
        end else begin
            if (adc_i_done && ((alert_en_eff[PMRA_AEN_ADC1] && i_over)
                || (alert_en_eff[PMRA_AEN_ADC4] && i_over && &over_hist_reg[2:0])))
                adc_alert_reg <= 1'b1;
            else if (clear_evt)
                adc_alert_reg <= 1'b0;
            if (overcurrent_live && alert_en_eff[PMRA_AEN_OC])
                overcurrent_latched <= 1'b1;
            else if (clear_evt)
                overcurrent_latched <= 1'b0;
            if (soft_off_bit && alert_en_eff[PMRA_AEN_OFF])
                off_alert_reg <= 1'b1;
            else if (clear_evt)
                off_alert_reg <= 1'b0;
        end
    end

    // Off status follows each write of the control register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            off_status_reg <= 1'b0;
        end else if (wr_evt && (wr_kind_reg == PMRA_EXT_CONTROL)) begin
            off_status_reg <= wr_data_reg[PMRA_CTRL_SOFTOFF];
        end
    end

    // Alert pin pulled low on a latched fault unless forced off
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            alert_oe_reg <= 1'b0;
        end else begin
            alert_oe_reg <= (adc_alert_reg || overcurrent_latched)
                            && !(soft_off_bit && alert_en_reg[PMRA_AEN_OFF]);
        end
    end
    assign alert_output_n_out = 1'b0;
    assign alert_output_n_oe  = alert_oe_reg;

    assign status_byte = {2'b00, off_alert_reg, off_status_reg, overcurrent_latched,
                          overcurrent_live, adc_alert_reg, adc_overcurrent_seen};

    // Newest codes held steady for the link to copy
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            v_hold_reg   <= '0;
            i_hold_reg   <= '0;
            data_tog_reg <= 1'b0;
        end else begin
            if (adc_v_done) v_hold_reg <= adc_v_code;
            if (adc_i_done) i_hold_reg <= adc_i_code;
            if (adc_v_done || adc_i_done) data_tog_reg <= ~data_tog_reg;
        end
    end

    assign conv_v_cont = cmd_reg[PMRA_CMD_V_CONT];
    assign conv_v_once = cmd_reg[PMRA_CMD_V_ONCE];
    assign conv_i_cont = cmd_reg[PMRA_CMD_I_CONT];
    assign conv_i_once = cmd_reg[PMRA_CMD_I_ONCE];
    assign vrange_sel  = cmd_reg[PMRA_CMD_VRANGE];

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: status bits, pending flag and data toggle come in here
    pmra_sync #(.WIDTH(PMRA_ST_W + 2)) u_link_sync (
        .clk (scl_clk),
        .rst (rst),
        .d   ({data_tog_reg, conv_v_once || conv_i_once, status_byte[PMRA_ST_W-1:0]}),
        .q   (link_sync_q)
    );
    assign pend_s     = link_sync_q[PMRA_ST_W];
    assign data_tog_s = link_sync_q[PMRA_ST_W+1];

    // Start crossing: first stage on the falling edge, second on the rising,
    // so the start is known by the second address bit
    always_ff @(negedge scl_clk or posedge rst) begin
        if (rst) start_meta_reg <= 1'b0;
        else     start_meta_reg <= start_tog_reg;
    end
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            start_s_reg    <= 1'b0;
            start_seen_reg <= 1'b0;
        end else begin
            start_s_reg    <= start_meta_reg;
            start_seen_reg <= start_s_reg;
        end
    end
    assign start_new = start_s_reg ^ start_seen_reg;

    // Data line is timed by the link clock itself, so it is sampled directly
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) shift_reg <= 8'h00;
        else     shift_reg <= byte_in;
    end
    assign byte_in = {shift_reg[6:0], sda_in};

    // Transfer sequencer
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            state_reg <= PMRA_IDLE;
            cnt_reg   <= 3'h0;
        end else if (start_new) begin
            state_reg <= PMRA_ADDR;
            cnt_reg   <= PMRA_BITS_AT_SEEN;
        end else begin
            case (state_reg)
                PMRA_ADDR: begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == PMRA_BIT_LAST) begin
                        if (byte_in[7:1] == SLAVE_ADDR && !(byte_in[0] && pend_s))
                            state_reg <= PMRA_ADDR_ACK;
                        else
                            state_reg <= PMRA_IDLE;
                    end
                end
                PMRA_ADDR_ACK: begin
                    cnt_reg   <= 3'h0;
                    state_reg <= rw_reg ? PMRA_RD_BYTE : PMRA_WR_BYTE;
                end
                PMRA_WR_BYTE: begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == PMRA_BIT_LAST) state_reg <= PMRA_WR_ACK;
                end
                PMRA_WR_ACK: begin
                    cnt_reg   <= 3'h0;
                    state_reg <= PMRA_WR_BYTE;
                end
                PMRA_RD_BYTE: begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == PMRA_BIT_LAST) state_reg <= PMRA_RD_ACK;
                end
                PMRA_RD_ACK: begin
                    cnt_reg   <= 3'h0;
                    state_reg <= sda_in ? PMRA_IDLE : PMRA_RD_BYTE;
                end
                default: state_reg <= PMRA_IDLE;
            endcase
        end
    end

    // Direction, byte index and the byte being shifted out
    assign idx_next = (idx_reg == 2'h3) ? idx_reg : idx_reg + 2'h1;
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            rw_reg  <= 1'b0;
            idx_reg <= 2'h0;
            tx_reg  <= 8'h00;
        end else begin
            if (state_reg == PMRA_ADDR && cnt_reg == PMRA_BIT_LAST)
                rw_reg <= byte_in[0];
            if (state_reg == PMRA_ADDR_ACK) begin
                idx_reg <= 2'h0;
                tx_reg  <= pmra_read_byte(2'h0, sel_v_reg, sel_i_reg, sel_st_reg,
                           v_snap_reg, i_snap_reg, {2'b00, link_sync_q[PMRA_ST_W-1:0]});
            end else if (state_reg == PMRA_RD_ACK && !sda_in) begin
                idx_reg <= idx_next;
                tx_reg  <= pmra_read_byte(idx_next, sel_v_reg, sel_i_reg, sel_st_reg,
                           v_snap_reg, i_snap_reg, {2'b00, link_sync_q[PMRA_ST_W-1:0]});
            end
        end
    end

    // Received bytes: command, or pointer then extended data
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            ptr_pend_reg <= 1'b0;
            ptr_reg      <= 2'h0;
            wr_tog_reg   <= 1'b0;
            wr_kind_reg  <= PMRA_WR_COMMAND;
            wr_data_reg  <= 8'h00;
            sel_v_reg    <= 1'b0;
            sel_i_reg    <= 1'b0;
            sel_st_reg   <= 1'b0;
        end else if (start_new) begin
            ptr_pend_reg <= 1'b0;
        end else if (state_reg == PMRA_WR_BYTE && cnt_reg == PMRA_BIT_LAST) begin
            if (ptr_pend_reg) begin
                ptr_pend_reg <= 1'b0;
                wr_kind_reg  <= ptr_reg;
                wr_data_reg  <= byte_in;
                wr_tog_reg   <= ~wr_tog_reg;
            end else if (byte_in[PMRA_EXT_FLAG_BIT]) begin
                ptr_pend_reg <= (byte_in[1:0] != PMRA_WR_COMMAND);
                ptr_reg      <= byte_in[1:0];
            end else begin
                wr_kind_reg <= PMRA_WR_COMMAND;
                wr_data_reg <= byte_in;
                wr_tog_reg  <= ~wr_tog_reg;
                sel_v_reg   <= byte_in[PMRA_CMD_V_CONT] || byte_in[PMRA_CMD_V_ONCE];
                sel_i_reg   <= byte_in[PMRA_CMD_I_CONT] || byte_in[PMRA_CMD_I_ONCE];
                sel_st_reg  <= byte_in[PMRA_CMD_STATUS];
            end
        end
    end

    // Codes copied only outside a read so bytes never tear; two conversions
    // inside one crossing can hide the first toggle
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            v_snap_reg    <= '0;
            i_snap_reg    <= '0;
            data_seen_reg <= 1'b0;
        end else if (data_tog_s != data_seen_reg && state_reg != PMRA_RD_BYTE
                     && state_reg != PMRA_RD_ACK && state_reg != PMRA_ADDR_ACK) begin
            v_snap_reg    <= v_hold_reg;
            i_snap_reg    <= i_hold_reg;
            data_seen_reg <= data_tog_s;
        end
    end

    // Drive changes on the falling edge, clear of the master's sampling
    always_ff @(negedge scl_clk or posedge rst) begin
        if (rst) begin
            sda_oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                PMRA_ADDR_ACK: sda_oe_reg <= 1'b1;
                PMRA_WR_ACK:   sda_oe_reg <= 1'b1;
                PMRA_RD_BYTE:  sda_oe_reg <= ~tx_reg[PMRA_BIT_LAST - cnt_reg];
                default:       sda_oe_reg <= 1'b0;
            endcase
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_reg;

endmodule
`default_nettype wire

// file: verification/pmra_chk.sv
// Port checker for the readback and alert block
`timescale 1ns/10ps
`default_nettype none
module pmra_chk (
    // Clocks, link and alert pins, converter handshake
    input wire logic core_clk, rst, scl_clk, sda_out, sda_oe,
    input wire logic alert_output_n_out, alert_output_n_oe,
    input wire logic adc_v_done, adc_i_done, conv_v_once, conv_i_once
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_sda_od; sda_out == 1'b0; endproperty
    a_sda_od: assert property (p_sda_od) else $error("sda out high");
    property p_al_od; alert_output_n_out == 1'b0; endproperty
    a_al_od: assert property (p_al_od) else $error("alert out high");
    property p_rst_q; disable iff (1'b0) rst |-> !sda_oe && !alert_output_n_oe; endproperty
    a_rst_q: assert property (p_rst_q) else $error("drive in reset");
    property p_quiet; $fell(rst) |-> !sda_oe [*3]; endproperty
    a_quiet: assert property (p_quiet) else $error("sda driven after reset");
    property p_hold; scl_clk && $past(scl_clk) |-> $stable(sda_oe); endproperty
    a_hold: assert property (p_hold) else $error("sda moved, scl high");
    property p_rise; $rose(sda_oe) |-> !scl_clk; endproperty
    a_rise: assert property (p_rise) else $error("sda drive, scl high");
    property p_vonce; conv_v_once && adc_v_done |=> !conv_v_once; endproperty
    a_vonce: assert property (p_vonce) else $error("v once stuck");
    property p_ionce; conv_i_once && adc_i_done |=> !conv_i_once; endproperty
    a_ionce: assert property (p_ionce) else $error("i once stuck");
endmodule
bind pmra_top pmra_chk chk_u (.core_clk, .rst, .scl_clk, .sda_out, .sda_oe, .alert_output_n_out,
    .alert_output_n_oe, .adc_v_done, .adc_i_done, .conv_v_once, .conv_i_once);
`default_nettype wire

// file: verification/pmra_mst.sv
// Bus master model for the serial link; clock stands high between frames
`timescale 1ns/10ps
`default_nettype none
module pmra_mst (
    // Clock out, line pull-down out, line level in
    output logic     scl, pull,
    input wire logic sda
);
    initial {scl, pull} = 2'b10;
    // Data moves while clock is low, read at the rising edge
    task automatic bitx(input logic b, output logic r);
        pull = ~b;
        #16 scl = 1'b1;
        r = sda;
        #32 scl = 1'b0;
        #16;
    endtask
    // Start and stop: line moves with clock high
    task automatic start();
        pull = 1'b1;
        #40 scl = 1'b0;
        #16;
    endtask
    task automatic stop();
        pull = 1'b1;
        #16 scl = 1'b1;
        #40 pull = 1'b0;
        #40;
    endtask
    // Byte then ninth bit; high ninth bit releases the line
    task automatic xb(input logic [7:0] w, input logic a, output logic [7:0] r, output logic k);
        for (int j = 7; j >= 0; j--) bitx(w[j], r[j]);
        bitx(a, k);
    endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench: readback layouts, status bits, alert pin
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        core_clk, rst, trip, vd, id;
    logic [11:0] vc, ic;
    wire logic   scl, pull, sda_oe, aoe;
    wire logic   sda = ~(pull | sda_oe);
    wire logic [4:0] cmdo;
    int          mismatches, checks;
    pmra_top dut_u (.core_clk, .rst, .scl_clk(scl), .sda_in(sda), .sda_out(), .sda_oe,
        .alert_output_n_out(), .alert_output_n_oe(aoe), .trip_compare_in(trip),
        .adc_v_done(vd), .adc_v_code(vc), .adc_i_done(id), .adc_i_code(ic),
        .conv_v_cont(cmdo[0]), .conv_v_once(cmdo[1]), .conv_i_cont(cmdo[2]),
        .conv_i_once(cmdo[3]), .vrange_sel(cmdo[4]));
    pmra_mst m_u (.scl, .pull, .sda);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %0t got %h want %h", $time, g, e);
        end
    endtask
    // Write frame; a zero second byte is not sent
    task automatic wr(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        logic       k;
        m_u.start();
        m_u.xb(8'h60, 1'b1, r, k);
        m_u.xb(a, 1'b1, r, k);
        if (b !== 8'h00) m_u.xb(b, 1'b1, r, k);
        m_u.stop();
        chk({7'h00, k}, 8'h00);
    endtask
    // Read frame; master nacks the last byte
    task automatic rd(input int n, input logic [23:0] e, input logic ok);
        logic [7:0] r;
        logic       k;
        m_u.start();
        m_u.xb(8'h61, 1'b1, r, k);
        chk({7'h00, k}, {7'h00, ~ok});
        for (int j = 0; j < n && ok; j++) begin
            m_u.xb(8'hff, j == n - 1, r, k);
            chk(r, e[23 - 8 * j -: 8]);
        end
        m_u.stop();
    endtask
    // Both channels convert, current code fixed above the low threshold
    task automatic conv(input logic [11:0] v);
        @(posedge core_clk);
        #1 {vd, id, vc, ic} = {2'b11, v, 12'h123};
        @(posedge core_clk);
        #1 {vd, id} = 2'b00;
    endtask
    task automatic t_data();
        wr(8'h82, 8'h10);
        wr(8'h81, 8'h05);
        repeat (3) conv(12'habc);
        wr(8'h40, 8'h00);
        rd(1, 24'h030000, 1'b1);
        chk({7'h00, aoe}, 8'h01);
        wr(8'h00, 8'h00);
        rd(3, 24'hab12c3, 1'b1);
        wr(8'h01, 8'h00);
        rd(2, 24'habc000, 1'b1);
        wr(8'h04, 8'h00);
        chk({3'h0, cmdo}, 8'h04);
        rd(2, 24'h123000, 1'b1);
    endtask
    // Comparator trip, soft-off override, clear with source still active
    task automatic t_alert();
        wr(8'h81, 8'h14);
        @(posedge core_clk);
        #1 trip = 1'b1;
        wr(8'h40, 8'h00);
        rd(1, 24'h0d0000, 1'b1);
        wr(8'h81, 8'h0c);
        wr(8'h83, 8'h01);
        rd(1, 24'h3d0000, 1'b1);
        chk({7'h00, aoe}, 8'h00);
        wr(8'h81, 8'h14);
        rd(1, 24'h1d0000, 1'b1);
        chk({7'h00, aoe}, 8'h01);
    endtask
    // Single shot refuses reads until its result lands
    task automatic t_once();
        wr(8'h1a, 8'h00);
        chk({3'h0, cmdo}, 8'h1a);
        rd(1, 24'h000000, 1'b0);
        conv(12'h5a5);
        chk({3'h0, cmdo}, 8'h10);
        rd(3, 24'h5a1253, 1'b1);
    endtask
    task automatic close_out();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {rst, trip, vd, id, vc, ic} = {4'h8, 24'h000000};
        {mismatches, checks} = {32'h0, 32'h0};
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge core_clk);
        t_data();
        t_alert();
        t_once();
        close_out();
    end
    // Whole run needs about 34 us; a hang is cut off well beyond that
    initial begin
        #200000;
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
